// *** rtl/mse_settings.sv ***
// Purpose: Numeric settings, compression parameters, ring counting and in-band escape detection.
// Assumes: Command decoding upstream presents one setting access per REQ_VALID pulse.
// Notes:   Answers come one cycle after the request; rejected writes leave the setting unchanged.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Auto-answer after that many rings, default 0.
// - Zero auto-answer count never answers.
// - Blind pause writes ignored, reads give 002.
// - Connect timeout seconds, default 60, 0 unlimited.
// - Comma pause seconds, default 2.
// - Disconnect delay tenths, default 100, 0/255 off.
// - Compression direction 0..3, default 0.
// - Disconnect on failed compression flag, default 0.
// - Dictionary size 512..2048, default 2048.
// - String length 6..32, default 20.
// - Compression report switch, default off.
// - Read-only ring counter since call setup.
// - Escape character 0..127, default plus sign.
// - Guard time fiftieths, default 50.
// - Three escape characters enter command state.
// - Escape needs idle guard before and after.
// - Guard zero disables escape detection.
// - Packet-session escape acts as terminal-ready loss.
// - Address type 128..255, default 129.
// - International prefix dials address type 145.
// - Call mode cleared by calls and resets.
// - Speaker and signalling commands accepted, ignored.
module mse_settings
  import mse_pkg::*;
#(
  parameter int GUARD_TICK = GUARD_TICK_CYCLES
)(
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        ARST_N,
  // Settings command port
  input  wire logic        REQ_VALID,
  input  wire logic        REQ_WRITE,
  input  wire logic [4:0]  REQ_SEL,
  input  wire logic [11:0] REQ_DATA,
  output logic             RSP_VALID,
  output logic             RSP_OK,
  output logic [11:0]      RSP_DATA,
  output logic [15:0]      RSP_DEC,
  // Call events
  input  wire logic        RING_IND,
  input  wire logic        CALL_SETUP,
  input  wire logic        ALT_CALL_DONE,
  input  wire logic        ANSWER_FAILED,
  input  wire logic        USER_RESET,
  input  wire logic        FACTORY_RESET,
  output logic             AUTO_ANSWER,
  output logic [7:0]       RING_COUNT,
  // Dialling
  input  wire logic        DIAL_INTL,
  output logic [7:0]       DIAL_ADDR_TYPE,
  // Data stream
  input  wire logic        ONLINE_DATA,
  input  wire logic        PACKET_SESSION,
  input  wire logic        RX_VALID,
  input  wire logic [7:0]  RX_CHAR,
  output logic             TX_VALID,
  output logic [7:0]       TX_CHAR,
  output logic             ESC_TO_COMMAND,
  output logic             PACKET_TERM,
  // Settings in force
  output mse_cfg_s         CFG
);

  function automatic logic write_ok(input logic [4:0] sel, input logic [11:0] d);
    logic ok;
    ok = 1'b0;
    unique case (sel)
      SEL_AUTO_ANSWER, SEL_BLIND_PAUSE, SEL_TIMEOUT, SEL_COMMA_PAUSE,
      SEL_DISC_DELAY, SEL_GUARD_TIME: ok = (d <= MAX_BYTE);
      SEL_ESC_CHAR:    ok = (d <= MAX_ESC_CHAR);
      SEL_COMP_DIR:    ok = (d <= MAX_COMP_DIR);
      SEL_COMP_NEG, SEL_COMP_REPORT, SEL_CALL_MODE, SEL_SIG_STD: ok = (d <= MAX_BIT);
      SEL_DICT_SIZE:   ok = (d >= MIN_DICT) && (d <= MAX_DICT);
      SEL_MAX_STRLEN:  ok = (d >= MIN_STRLEN) && (d <= MAX_STRLEN);
      SEL_ADDR_TYPE:   ok = (d >= MIN_ADDR) && (d <= MAX_BYTE);
      SEL_SPK_LOUD:    ok = (d <= MAX_SPK_LOUD);
      SEL_SPK_MODE:    ok = (d <= MAX_SPK_MODE);
      default:         ok = 1'b0;
    endcase
    return ok;
  endfunction : write_ok

  // Binary to four decimal digits by shift-and-add-three.
  function automatic logic [15:0] to_dec(input logic [11:0] v);
    logic [27:0] s;
    s = {16'h0000, v};
    for (int i = 0; i < 12; i++)
    begin
      for (int j = 0; j < 4; j++)
      begin
        if (s[12+4*j +: 4] > 4'h4)
          s[12+4*j +: 4] = s[12+4*j +: 4] + 4'h3;
      end
      s = {s[26:0], 1'b0};
    end
    return s[27:12];
  endfunction : to_dec

  logic [7:0]  aa_reg,     aa_next;
  logic [7:0]  tmo_reg,    tmo_next;
  logic [7:0]  comma_reg,  comma_next;
  logic [7:0]  disc_reg,   disc_next;
  logic [6:0]  esc_reg,    esc_next;
  logic [7:0]  guard_reg,  guard_next;
  logic [1:0]  dir_reg,    dir_next;
  logic        neg_reg,    neg_next;
  logic [11:0] dict_reg,   dict_next;
  logic [5:0]  slen_reg,   slen_next;
  logic        rep_reg,    rep_next;
  logic [7:0]  addr_reg,   addr_next;
  logic        mode_reg,   mode_next;
  logic [7:0]  ring_reg,   ring_next;
  logic        ans_reg;
  logic        rsp_v_reg,  rsp_ok_reg;
  logic [11:0] rsp_d_reg;
  logic [15:0] rsp_dec_reg;
  logic [7:0]  dial_reg;
  logic        txv_reg;
  logic [7:0]  txc_reg;
  logic        esc_cmd_reg, pkt_term_reg;
  logic [19:0] tick_reg,   tick_next;
  logic [7:0]  idle_reg,   idle_next;
  mse_esc_e    st_reg,     st_next;
  logic [11:0] rd_val;
  logic        rd_ok;

  wire soft_rst  = USER_RESET | FACTORY_RESET;
  wire wr_ok     = REQ_VALID & REQ_WRITE & write_ok(REQ_SEL, REQ_DATA);
  wire wr_byte   = wr_ok & ~soft_rst;
  wire mode_clr  = soft_rst | ALT_CALL_DONE | ANSWER_FAILED;

  // A rejected value never reaches a setting, so each next value is a plain select.
  assign aa_next    = soft_rst ? RST_AUTO_ANSWER : (wr_byte && REQ_SEL == SEL_AUTO_ANSWER) ? REQ_DATA[7:0] : aa_reg;
  assign tmo_next   = soft_rst ? RST_TIMEOUT : (wr_byte && REQ_SEL == SEL_TIMEOUT) ? REQ_DATA[7:0] : tmo_reg;
  assign comma_next = soft_rst ? RST_COMMA_PAUSE : (wr_byte && REQ_SEL == SEL_COMMA_PAUSE) ? REQ_DATA[7:0] : comma_reg;
  assign disc_next  = soft_rst ? RST_DISC_DELAY : (wr_byte && REQ_SEL == SEL_DISC_DELAY) ? REQ_DATA[7:0] : disc_reg;
  assign esc_next   = soft_rst ? RST_ESC_CHAR : (wr_byte && REQ_SEL == SEL_ESC_CHAR) ? REQ_DATA[6:0] : esc_reg;
  assign guard_next = soft_rst ? RST_GUARD_TIME : (wr_byte && REQ_SEL == SEL_GUARD_TIME) ? REQ_DATA[7:0] : guard_reg;
  assign dir_next   = soft_rst ? RST_COMP_DIR : (wr_byte && REQ_SEL == SEL_COMP_DIR) ? REQ_DATA[1:0] : dir_reg;
  assign neg_next   = soft_rst ? 1'b0 : (wr_byte && REQ_SEL == SEL_COMP_NEG) ? REQ_DATA[0] : neg_reg;
  assign dict_next  = soft_rst ? RST_DICT_SIZE : (wr_byte && REQ_SEL == SEL_DICT_SIZE) ? REQ_DATA : dict_reg;
  assign slen_next  = soft_rst ? RST_MAX_STRLEN : (wr_byte && REQ_SEL == SEL_MAX_STRLEN) ? REQ_DATA[5:0] : slen_reg;
  assign rep_next   = soft_rst ? 1'b0 : (wr_byte && REQ_SEL == SEL_COMP_REPORT) ? REQ_DATA[0] : rep_reg;
  assign addr_next  = soft_rst ? RST_ADDR_TYPE : (wr_byte && REQ_SEL == SEL_ADDR_TYPE) ? REQ_DATA[7:0] : addr_reg;
  // Clearing wins over a host write so an alternating call is never left armed by accident.
  assign mode_next  = mode_clr ? 1'b0 : (wr_byte && REQ_SEL == SEL_CALL_MODE) ? REQ_DATA[0] : mode_reg;

  // A new call setup restarts the count; a ring in the same cycle is counted, not lost.
  wire [7:0] ring_base = CALL_SETUP ? 8'h00 : ring_reg;
  wire       ring_inc  = RING_IND & (ring_base != 8'hff);
  assign ring_next = ring_inc ? ring_base + 8'h01 : ring_base;
  wire answer_now = ring_inc && (aa_reg != 8'h00) && (ring_next == aa_reg);

  // Read selection; the three unused command groups answer success and store nothing.
  always_comb
  begin
    rd_val = 12'h000;
    rd_ok  = 1'b1;
    unique case (REQ_SEL)
      SEL_AUTO_ANSWER: rd_val = {4'h0, aa_reg};
      SEL_RING_COUNT:  rd_val = {4'h0, ring_reg};
      SEL_ESC_CHAR:    rd_val = {5'h00, esc_reg};
      SEL_BLIND_PAUSE: rd_val = BLIND_PAUSE_READ;
      SEL_TIMEOUT:     rd_val = {4'h0, tmo_reg};
      SEL_COMMA_PAUSE: rd_val = {4'h0, comma_reg};
      SEL_DISC_DELAY:  rd_val = {4'h0, disc_reg};
      SEL_GUARD_TIME:  rd_val = {4'h0, guard_reg};
      SEL_COMP_DIR:    rd_val = {10'h000, dir_reg};
      SEL_COMP_NEG:    rd_val = {11'h000, neg_reg};
      SEL_DICT_SIZE:   rd_val = dict_reg;
      SEL_MAX_STRLEN:  rd_val = {6'h00, slen_reg};
      SEL_COMP_REPORT: rd_val = {11'h000, rep_reg};
      SEL_ADDR_TYPE:   rd_val = {4'h0, addr_reg};
      SEL_CALL_MODE:   rd_val = {11'h000, mode_reg};
      SEL_SPK_LOUD, SEL_SPK_MODE, SEL_SIG_STD: rd_val = 12'h000;
      default:         rd_ok  = 1'b0;
    endcase
  end

  wire rsp_ok_now = REQ_WRITE ? write_ok(REQ_SEL, REQ_DATA) : rd_ok;

  // Escape detection: the guard is counted in whole fiftieths since the last character.
  wire tick      = (tick_reg == 20'(GUARD_TICK - 1));
  assign tick_next = (RX_VALID || tick) ? 20'h00000 : tick_reg + 20'h00001;
  assign idle_next = RX_VALID ? 8'h00 : (tick && idle_reg != 8'hff) ? idle_reg + 8'h01 : idle_reg;
  wire guard_met = (idle_reg >= guard_reg);
  wire esc_en    = ONLINE_DATA && (guard_reg != 8'h00);
  wire is_esc    = (RX_CHAR == {1'b0, esc_reg});
  wire esc_hit   = esc_en && (st_reg == ESC_GOT3) && !RX_VALID && guard_met;

  always_comb
  begin
    st_next = st_reg;
    if (!esc_en)
      st_next = ESC_WAIT;
    else
      unique case (st_reg)
        ESC_WAIT: if (RX_VALID && is_esc && guard_met) st_next = ESC_GOT1;
        ESC_GOT1: if (RX_VALID) st_next = is_esc ? ESC_GOT2 : ESC_WAIT;
        ESC_GOT2: if (RX_VALID) st_next = is_esc ? ESC_GOT3 : ESC_WAIT;
        ESC_GOT3: if (RX_VALID || guard_met) st_next = ESC_WAIT;
      endcase
  end

  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      aa_reg    <= RST_AUTO_ANSWER;
      tmo_reg   <= RST_TIMEOUT;
      comma_reg <= RST_COMMA_PAUSE;
      disc_reg  <= RST_DISC_DELAY;
      esc_reg   <= RST_ESC_CHAR;
      guard_reg <= RST_GUARD_TIME;
      dir_reg   <= RST_COMP_DIR;
      neg_reg   <= 1'b0;
      dict_reg  <= RST_DICT_SIZE;
      slen_reg  <= RST_MAX_STRLEN;
      rep_reg   <= 1'b0;
      addr_reg  <= RST_ADDR_TYPE;
      mode_reg  <= 1'b0;
      ring_reg  <= 8'h00;
    end
    else
    begin
      aa_reg    <= aa_next;
      tmo_reg   <= tmo_next;
      comma_reg <= comma_next;
      disc_reg  <= disc_next;
      esc_reg   <= esc_next;
      guard_reg <= guard_next;
      dir_reg   <= dir_next;
      neg_reg   <= neg_next;
      dict_reg  <= dict_next;
      slen_reg  <= slen_next;
      rep_reg   <= rep_next;
      addr_reg  <= addr_next;
      mode_reg  <= mode_next;
      ring_reg  <= ring_next;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rsp_v_reg   <= 1'b0;
      rsp_ok_reg  <= 1'b0;
      rsp_d_reg   <= 12'h000;
      rsp_dec_reg <= 16'h0000;
      ans_reg     <= 1'b0;
      dial_reg    <= RST_ADDR_TYPE;
    end
    else
    begin
      rsp_v_reg   <= REQ_VALID;
      rsp_ok_reg  <= REQ_VALID & rsp_ok_now;
      rsp_d_reg   <= rd_val;
      rsp_dec_reg <= to_dec(rd_val);
      ans_reg     <= answer_now;
      dial_reg    <= DIAL_INTL ? ADDR_TYPE_INTL : addr_reg;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      tick_reg     <= 20'h00000;
      idle_reg     <= 8'h00;
      st_reg       <= ESC_WAIT;
      txv_reg      <= 1'b0;
      txc_reg      <= 8'h00;
      esc_cmd_reg  <= 1'b0;
      pkt_term_reg <= 1'b0;
    end
    else
    begin
      tick_reg     <= tick_next;
      idle_reg     <= idle_next;
      st_reg       <= st_next;
      txv_reg      <= RX_VALID & ONLINE_DATA;
      txc_reg      <= RX_CHAR;
      esc_cmd_reg  <= esc_hit & ~PACKET_SESSION;
      pkt_term_reg <= esc_hit & PACKET_SESSION;
    end
  end

  assign RSP_VALID      = rsp_v_reg;
  assign RSP_OK         = rsp_ok_reg;
  assign RSP_DATA       = rsp_d_reg;
  assign RSP_DEC        = rsp_dec_reg;
  assign AUTO_ANSWER    = ans_reg;
  assign RING_COUNT     = ring_reg;
  assign DIAL_ADDR_TYPE = dial_reg;
  assign TX_VALID       = txv_reg;
  assign TX_CHAR        = txc_reg;
  assign ESC_TO_COMMAND = esc_cmd_reg;
  assign PACKET_TERM    = pkt_term_reg;

  // The disabling values are decoded here so downstream timers never need to know them.
  assign CFG = '{auto_answer: aa_reg, timeout_sec: tmo_reg,
                 timeout_unlimited: (tmo_reg == 8'h00),
                 comma_pause_sec: comma_reg, disc_delay: disc_reg,
                 auto_disc_en: (disc_reg != 8'h00) && (disc_reg != DISC_NEVER),
                 comp_dir: dir_reg, comp_disc_on_fail: neg_reg, dict_size: dict_reg,
                 max_strlen: slen_reg, comp_report_en: rep_reg, call_mode: mode_reg,
                 escape_char: esc_reg, guard_time: guard_reg};

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);

  a_answer_count:    assert property (AUTO_ANSWER |-> RING_COUNT == $past(aa_reg))
    else $error("auto answer at wrong ring count");
  a_answer_zero_off: assert property (AUTO_ANSWER |-> $past(aa_reg) != 8'h00)
    else $error("auto answer while disabled");
  a_blind_fixed:     assert property (REQ_VALID && !REQ_WRITE && REQ_SEL == SEL_BLIND_PAUSE
                                      |=> RSP_OK && RSP_DATA == 12'h002 && RSP_DEC == 16'h0002)
    else $error("blind pause read not 002");
  a_timeout_unlim:   assert property (REQ_VALID && REQ_WRITE && REQ_SEL == SEL_TIMEOUT && !soft_rst
                                      && REQ_DATA[11:8] == 4'h0
                                      |=> CFG.timeout_unlimited == ($past(REQ_DATA) == 12'h000))
    else $error("unlimited timeout flag wrong");
  a_disc_disable:    assert property (REQ_VALID && REQ_WRITE && REQ_SEL == SEL_DISC_DELAY && !soft_rst
                                      && (REQ_DATA == 12'h000 || REQ_DATA == 12'h0ff)
                                      |=> !CFG.auto_disc_en)
    else $error("auto disconnect enable wrong");
  a_dict_reject:     assert property (REQ_VALID && REQ_WRITE && REQ_SEL == SEL_DICT_SIZE
                                      && (REQ_DATA < 12'h200 || REQ_DATA > 12'h800)
                                      |=> !RSP_OK && $stable(CFG.dict_size))
    else $error("bad dictionary size accepted");
  a_strlen_range:    assert property (CFG.max_strlen >= 6'h06 && CFG.max_strlen <= 6'h20)
    else $error("string length out of range");
  a_esc_char_range:  assert property (REQ_VALID && REQ_WRITE && REQ_SEL == SEL_ESC_CHAR && REQ_DATA > 12'h07f
                                      |=> !RSP_OK)
    else $error("escape character above 127 accepted");
  a_esc_guard_off:   assert property ((ESC_TO_COMMAND || PACKET_TERM) |-> $past(guard_reg) != 8'h00
                                      && $past(idle_reg) >= $past(guard_reg))
    else $error("escape without guard");
  a_esc_packet:      assert property (PACKET_TERM |-> !ESC_TO_COMMAND && $past(PACKET_SESSION))
    else $error("packet escape misrouted");
  a_intl_type:       assert property (DIAL_INTL |=> DIAL_ADDR_TYPE == 8'h91)
    else $error("international address type not 145");
  a_mode_clear:      assert property ((ALT_CALL_DONE || ANSWER_FAILED || USER_RESET || FACTORY_RESET)
                                      |=> !CFG.call_mode)
    else $error("call mode not cleared");
  a_ring_read:       assert property (REQ_VALID && !REQ_WRITE && REQ_SEL == SEL_RING_COUNT
                                      |=> RSP_DATA == {4'h0, $past(RING_COUNT)})
    else $error("ring counter read wrong");
  a_abandon_esc:     assert property (st_reg == ESC_GOT1 && RX_VALID && !is_esc |=> st_reg == ESC_WAIT)
    else $error("escape candidate kept after other character");
  a_ring_restart:    assert property (CALL_SETUP |=> RING_COUNT == {7'h00, $past(RING_IND)})
    else $error("ring counter not restarted by call setup");
  a_pass_through:    assert property (RX_VALID && ONLINE_DATA |=> TX_VALID && TX_CHAR == $past(RX_CHAR))
    else $error("received character not passed as data");
  a_esc_held_off:    assert property (guard_reg == 8'h00 |=> st_reg == ESC_WAIT)
    else $error("escape detector active with zero guard");
  a_report_write:    assert property (REQ_VALID && REQ_WRITE && REQ_SEL == SEL_COMP_REPORT && !soft_rst
                                      && REQ_DATA <= 12'h001 |=> CFG.comp_report_en == $past(REQ_DATA[0]))
    else $error("compression report switch not stored");

  c_escape:      cover property (ESC_TO_COMMAND);
  c_packet_term: cover property (PACKET_TERM);
  c_auto_answer: cover property (AUTO_ANSWER);
  c_reject:      cover property (RSP_VALID && !RSP_OK);
  c_abandon:     cover property (st_reg == ESC_GOT1 && RX_VALID && !is_esc);

endmodule : mse_settings

`default_nettype wire

// *** rtl/mse_pkg.sv ***
// Purpose: Shared constants and types for the modem settings and escape control block.
// Assumes: One 40 MHz clock; all event inputs come from logic on that clock.
// Notes:   Setting select codes, reset values, ranges and guard timing live here.
package mse_pkg;

  // Setting select codes on the settings command port.
  localparam logic [4:0] SEL_AUTO_ANSWER = 5'h00;
  localparam logic [4:0] SEL_RING_COUNT  = 5'h01;
  localparam logic [4:0] SEL_ESC_CHAR    = 5'h02;
  localparam logic [4:0] SEL_BLIND_PAUSE = 5'h06;
  localparam logic [4:0] SEL_TIMEOUT     = 5'h07;
  localparam logic [4:0] SEL_COMMA_PAUSE = 5'h08;
  localparam logic [4:0] SEL_DISC_DELAY  = 5'h0a;
  localparam logic [4:0] SEL_GUARD_TIME  = 5'h0c;
  localparam logic [4:0] SEL_COMP_DIR    = 5'h10;
  localparam logic [4:0] SEL_COMP_NEG    = 5'h11;
  localparam logic [4:0] SEL_DICT_SIZE   = 5'h12;
  localparam logic [4:0] SEL_MAX_STRLEN  = 5'h13;
  localparam logic [4:0] SEL_COMP_REPORT = 5'h14;
  localparam logic [4:0] SEL_ADDR_TYPE   = 5'h15;
  localparam logic [4:0] SEL_CALL_MODE   = 5'h16;
  localparam logic [4:0] SEL_SPK_LOUD    = 5'h18;
  localparam logic [4:0] SEL_SPK_MODE    = 5'h19;
  localparam logic [4:0] SEL_SIG_STD     = 5'h1a;

  // Reset values.
  localparam logic [7:0]  RST_AUTO_ANSWER = 8'h00;
  localparam logic [7:0]  RST_TIMEOUT     = 8'h3c;
  localparam logic [7:0]  RST_COMMA_PAUSE = 8'h02;
  localparam logic [7:0]  RST_DISC_DELAY  = 8'h64;
  localparam logic [6:0]  RST_ESC_CHAR    = 7'h2b;
  localparam logic [7:0]  RST_GUARD_TIME  = 8'h32;
  localparam logic [1:0]  RST_COMP_DIR    = 2'h0;
  localparam logic [11:0] RST_DICT_SIZE   = 12'h800;
  localparam logic [5:0]  RST_MAX_STRLEN  = 6'h14;
  localparam logic [7:0]  RST_ADDR_TYPE   = 8'h81;

  // Fixed answers and special values.
  localparam logic [11:0] BLIND_PAUSE_READ = 12'h002;
  localparam logic [7:0]  ADDR_TYPE_INTL   = 8'h91;
  localparam logic [7:0]  DISC_NEVER       = 8'hff;

  // Accepted argument ranges, all at the width of the command data.
  localparam logic [11:0] MAX_BYTE     = 12'h0ff;
  localparam logic [11:0] MAX_ESC_CHAR = 12'h07f;
  localparam logic [11:0] MIN_ADDR     = 12'h080;
  localparam logic [11:0] MAX_COMP_DIR = 12'h003;
  localparam logic [11:0] MAX_BIT      = 12'h001;
  localparam logic [11:0] MIN_DICT     = 12'h200;
  localparam logic [11:0] MAX_DICT     = 12'h800;
  localparam logic [11:0] MIN_STRLEN   = 12'h006;
  localparam logic [11:0] MAX_STRLEN   = 12'h020;
  localparam logic [11:0] MAX_SPK_LOUD = 12'h003;
  localparam logic [11:0] MAX_SPK_MODE = 12'h002;

  // Guard time unit of one fiftieth of a second.
  localparam int CLK_HZ            = 40_000_000;
  localparam int GUARD_UNIT_MS     = 20;
  localparam int GUARD_TICK_CYCLES = CLK_HZ / 1000 * GUARD_UNIT_MS;

  typedef enum logic [1:0] {
    ESC_WAIT = 2'b00,
    ESC_GOT1 = 2'b01,
    ESC_GOT2 = 2'b11,
    ESC_GOT3 = 2'b10
  } mse_esc_e;

  typedef struct packed {
    logic [7:0]  auto_answer;
    logic [7:0]  timeout_sec;
    logic        timeout_unlimited;
    logic [7:0]  comma_pause_sec;
    logic [7:0]  disc_delay;
    logic        auto_disc_en;
    logic [1:0]  comp_dir;
    logic        comp_disc_on_fail;
    logic [11:0] dict_size;
    logic [5:0]  max_strlen;
    logic        comp_report_en;
    logic        call_mode;
    logic [6:0]  escape_char;
    logic [7:0]  guard_time;
  } mse_cfg_s;

endpackage : mse_pkg

// *** tb/mse_host_model.sv ***
// Purpose: Host terminal model that feeds characters into the block's data stream.
// Assumes: Characters are launched on the rising edge, one strobe cycle each.
// Notes:   The tb calls send and escape hierarchically.
`timescale 1ns/1ps
`default_nettype none
module mse_host_model (
  // Clock
  input  wire logic       clk,
  // Character stream
  output var  logic       rx_valid,
  output var  logic [7:0] rx_char
);
  initial
  begin
    rx_valid = 1'b0;
    rx_char  = 8'h00;
  end

  // Between characters the line shows the complement, so a stale value never looks like fresh data.
  task automatic send(input logic [7:0] c);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_char  <= c;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_char  <= ~c;
  endtask : send

  task automatic escape(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] c3, input int idle);
    repeat (idle) @(posedge clk);
    send(c1);
    send(c2);
    send(c3);
  endtask : escape
endmodule : mse_host_model
`default_nettype wire

// *** tb/tb_modem_sreg_escape_control.sv ***
// Purpose: Self-checking bench for the modem settings and escape block.
// Assumes: GUARD_TICK shortened to 4 cycles so a guard of 1 takes 4 cycles.
// Notes:   Expected values are written from the setting ranges and defaults.
`timescale 1ns/1ps
`default_nettype none
module tb_modem_sreg_escape_control;
  import mse_pkg::*;
  logic REF_CLK = 1'b0, ARST_N = 1'b0, REQ_VALID = 1'b0, REQ_WRITE = 1'b0;
  logic [4:0] REQ_SEL = 5'h00;
  logic [11:0] REQ_DATA = 12'h000;
  logic RING_IND = 1'b0, CALL_SETUP = 1'b0, ALT_CALL_DONE = 1'b0, ANSWER_FAILED = 1'b0;
  logic USER_RESET = 1'b0, FACTORY_RESET = 1'b0, DIAL_INTL = 1'b0, ONLINE_DATA = 1'b0, PACKET_SESSION = 1'b0;
  logic RSP_VALID, RSP_OK, AUTO_ANSWER, RX_VALID, TX_VALID, ESC_TO_COMMAND, PACKET_TERM;
  logic [11:0] RSP_DATA;
  logic [15:0] RSP_DEC;
  logic [7:0] RING_COUNT, DIAL_ADDR_TYPE, RX_CHAR, TX_CHAR;
  mse_cfg_s CFG;
  int miscompares = 0, compares = 0;
  logic [19:0] dft [15] = '{20'h00_000, 20'h02_02b, 20'h06_002, 20'h07_03c, 20'h08_002, 20'h0a_064,
    20'h0c_032, 20'h10_000, 20'h11_000, 20'h12_800, 20'h13_014, 20'h14_000, 20'h15_081, 20'h16_000, 20'h01_000};
  logic [23:0] rng [28] = '{24'h0_12_1ff, 24'h1_12_200, 24'h0_12_801, 24'h0_13_005, 24'h1_13_006,
    24'h0_13_021, 24'h1_13_020, 24'h0_02_080, 24'h1_02_07f, 24'h0_15_07f, 24'h1_15_080, 24'h0_10_004,
    24'h1_10_003, 24'h0_11_002, 24'h1_14_001, 24'h0_16_002, 24'h0_01_005, 24'h1_06_009, 24'h1_18_003,
    24'h0_18_004, 24'h1_19_002, 24'h1_1a_001, 24'h0_1a_002, 24'h0_1f_000, 24'h0_00_100, 24'h1_0a_000,
    24'h1_08_0ff, 24'h1_11_001};

  always #12.5 REF_CLK = ~REF_CLK;

  mse_host_model u_host (.clk(REF_CLK), .rx_valid(RX_VALID), .rx_char(RX_CHAR));
  mse_settings #(.GUARD_TICK(4)) u_dut (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .REQ_VALID(REQ_VALID),
    .REQ_WRITE(REQ_WRITE), .REQ_SEL(REQ_SEL), .REQ_DATA(REQ_DATA), .RSP_VALID(RSP_VALID), .RSP_OK(RSP_OK),
    .RSP_DATA(RSP_DATA), .RSP_DEC(RSP_DEC), .RING_IND(RING_IND), .CALL_SETUP(CALL_SETUP),
    .ALT_CALL_DONE(ALT_CALL_DONE), .ANSWER_FAILED(ANSWER_FAILED), .USER_RESET(USER_RESET),
    .FACTORY_RESET(FACTORY_RESET), .AUTO_ANSWER(AUTO_ANSWER), .RING_COUNT(RING_COUNT),
    .DIAL_INTL(DIAL_INTL), .DIAL_ADDR_TYPE(DIAL_ADDR_TYPE), .ONLINE_DATA(ONLINE_DATA),
    .PACKET_SESSION(PACKET_SESSION), .RX_VALID(RX_VALID), .RX_CHAR(RX_CHAR), .TX_VALID(TX_VALID),
    .TX_CHAR(TX_CHAR), .ESC_TO_COMMAND(ESC_TO_COMMAND), .PACKET_TERM(PACKET_TERM), .CFG(CFG));

  function automatic logic [15:0] dec(input logic [11:0] v);
    dec = {4'(v / 1000), 4'((v / 100) % 10), 4'((v / 10) % 10), 4'(v % 10)};
  endfunction : dec

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  task automatic end_sim;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  // On reads d is the expected value; on writes it is the value sent.
  task automatic acc(input logic w, input logic [4:0] s, input logic [11:0] d, input logic ok);
    @(posedge REF_CLK);
    REQ_VALID <= 1'b1;
    REQ_WRITE <= w;
    REQ_SEL   <= s;
    REQ_DATA  <= d;
    @(posedge REF_CLK);
    REQ_VALID <= 1'b0;
    #1;
    chk(16'(RSP_VALID), 16'h0001);
    chk(16'(RSP_OK), 16'(ok));
    if (!w)
    begin
      chk(16'(RSP_DATA), 16'(d));
      chk(RSP_DEC, dec(d));
    end
  endtask : acc

  task automatic ring(input logic setup, input logic [7:0] cnt, input logic aa);
    @(posedge REF_CLK);
    RING_IND   <= 1'b1;
    CALL_SETUP <= setup;
    @(posedge REF_CLK);
    RING_IND   <= 1'b0;
    CALL_SETUP <= 1'b0;
    #1;
    chk(16'(RING_COUNT), 16'(cnt));
    chk(16'(AUTO_ANSWER), 16'(aa));
  endtask : ring

  // The pulse must land within 30 cycles of the third character; code 1 circuit, 2 packet.
  task automatic esc_try(input logic [7:0] c2, input logic [15:0] exp);
    logic [15:0] got;
    got = 16'h0000;
    u_host.escape(8'h2b, c2, 8'h2b, 12);
    repeat (30)
    begin
      @(posedge REF_CLK);
      #1;
      got = got | {14'h0, PACKET_TERM, ESC_TO_COMMAND};
    end
    chk(got, exp);
  endtask : esc_try

  task automatic evt(input logic [3:0] e);
    @(posedge REF_CLK);
    {ALT_CALL_DONE, ANSWER_FAILED, USER_RESET, FACTORY_RESET} <= e;
    @(posedge REF_CLK);
    {ALT_CALL_DONE, ANSWER_FAILED, USER_RESET, FACTORY_RESET} <= 4'h0;
  endtask : evt

  initial
  begin
    repeat (6) @(posedge REF_CLK);
    ARST_N <= 1'b1;
    foreach (dft[i]) acc(1'b0, dft[i][16:12], dft[i][11:0], 1'b1);
    chk(16'({CFG.auto_disc_en, CFG.timeout_unlimited}), 16'h0002);
    ring(1'b1, 8'h01, 1'b0);
    ring(1'b0, 8'h02, 1'b0);
    acc(1'b1, 5'h00, 12'h002, 1'b1);
    ring(1'b1, 8'h01, 1'b0);
    ring(1'b0, 8'h02, 1'b1);
    ring(1'b0, 8'h03, 1'b0);
    acc(1'b0, 5'h01, 12'h003, 1'b1);
    ONLINE_DATA <= 1'b1;
    acc(1'b1, 5'h0c, 12'h001, 1'b1);
    u_host.send(8'h5a);
    #1;
    chk({7'h0, TX_VALID, TX_CHAR}, 16'h015a);
    esc_try(8'h2b, 16'h0001);
    PACKET_SESSION <= 1'b1;
    esc_try(8'h2b, 16'h0002);
    PACKET_SESSION <= 1'b0;
    esc_try(8'h41, 16'h0000);
    acc(1'b1, 5'h0c, 12'h000, 1'b1);
    esc_try(8'h2b, 16'h0000);
    foreach (rng[i]) acc(1'b1, rng[i][16:12], rng[i][11:0], rng[i][20]);
    acc(1'b0, 5'h12, 12'h200, 1'b1);
    acc(1'b0, 5'h13, 12'h020, 1'b1);
    acc(1'b0, 5'h02, 12'h07f, 1'b1);
    acc(1'b0, 5'h06, 12'h002, 1'b1);
    acc(1'b0, 5'h08, 12'h0ff, 1'b1);
    acc(1'b0, 5'h11, 12'h001, 1'b1);
    acc(1'b0, 5'h14, 12'h001, 1'b1);
    chk(16'(CFG.auto_disc_en), 16'h0000);
    acc(1'b1, 5'h0a, 12'h0ff, 1'b1);
    acc(1'b1, 5'h07, 12'h000, 1'b1);
    #1;
    chk(16'({CFG.auto_disc_en, CFG.timeout_unlimited}), 16'h0001);
    repeat (2) @(posedge REF_CLK);
    #1;
    chk(16'(DIAL_ADDR_TYPE), 16'h0080);
    DIAL_INTL <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    #1;
    chk(16'(DIAL_ADDR_TYPE), 16'h0091);
    for (int i = 0; i < 4; i++)
    begin
      acc(1'b1, 5'h16, 12'h001, 1'b1);
      evt(4'h8 >> i);
      acc(1'b0, 5'h16, 12'h000, 1'b1);
    end
    acc(1'b0, 5'h0c, 12'h032, 1'b1);
    end_sim();
  end
endmodule : tb_modem_sreg_escape_control
`default_nettype wire
